// >>> hw/bcc_bcd_step.sv
// Two-digit BCD step with wrap from a limit back to a base value
`timescale 1ns/1ps
`default_nettype none
module bcc_bcd_step
  import bcc_pkg::*;
(
  // Field value and limits
  input wire logic [7:0] val_i,
  input wire logic [7:0] max_i,
  input wire logic [7:0] min_i,
  // Stepped value and wrap flag
  output logic [7:0] next_o,
  output logic wrap_o
);

  // BCD increment with decimal carry between digits
  always_comb
  begin
    wrap_o = 1'b0;
    if (val_i >= max_i)
    begin
      next_o = min_i;
      wrap_o = 1'b1;
    end
    else if (val_i[3:0] >= BCC_BCD_NINE[3:0])
      next_o = {4'(val_i[7:4] + 4'h1), 4'h0};
    else
      next_o = {val_i[7:4], 4'(val_i[3:0] + 4'h1)};
  end

endmodule
`default_nettype wire

// >>> hw/bcc_clock.sv
// Calendar clock with BCD time words, halt/load setting and thirty-second rounding
`timescale 1ns/1ps
`default_nettype none
module bcc_clock
  import bcc_pkg::*;
#(
  parameter int SECOND_CYCLES = BCC_SECOND_CYCLES
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Cassette presence pin
  input wire logic cassette_present_i,
  // Word access port
  input wire logic [7:0] addr_i,
  input wire logic wr_en_i,
  input wire logic [15:0] wr_data_i,
  input wire logic rd_en_i,
  output logic [15:0] rd_data_o,
  // Status
  output logic running_o
);

  bcc_time_t time_reg, time_next;
  logic [15:0] quick_reg, quick_next;
  logic halt_reg, halt_next;
  logic load_reg, load_next;
  logic round_reg, round_next;
  logic [BCC_PRESC_W-1:0] presc_reg, presc_next;
  logic [15:0] rd_data_reg, rd_data_next;
  logic running_reg, running_next;
  logic cas_meta_reg, cas_ok_reg;
  logic tick, tick_run, round_up, wr_ctl;
  logic min_step, hour_step, day_step, month_step, year_step;
  logic [7:0] dmax;
  bcc_time_t step;
  logic s_wrap, m_wrap, h_wrap, d_wrap, mo_wrap;

  // Presence pin through two flip-flops
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cas_meta_reg <= 1'b0;
      cas_ok_reg <= 1'b0;
    end
    else
    begin
      cas_meta_reg <= cassette_present_i;
      cas_ok_reg <= cas_meta_reg;
    end
  end

  // Carry chain terms
  assign tick = (presc_reg == BCC_PRESC_W'(SECOND_CYCLES - 1));
  assign tick_run = tick && running_reg;
  assign wr_ctl = wr_en_i && (addr_i == BCC_OFS_WDAY_CTL);
  assign round_up = round_reg && (time_reg.second >= BCC_SEC_HALF);
  assign min_step = (tick_run && s_wrap) || round_up;
  assign hour_step = min_step && m_wrap;
  assign day_step = hour_step && h_wrap;
  assign month_step = day_step && d_wrap;
  assign year_step = month_step && mo_wrap;
  assign dmax = bcc_month_days(time_reg.month, time_reg.year);

  // one BCD step cell per field
  bcc_bcd_step u_sec (.val_i(time_reg.second), .max_i(BCC_SEC_MAX), .min_i(BCC_BCD_ZERO),
    .next_o(step.second), .wrap_o(s_wrap));
  bcc_bcd_step u_min (.val_i(time_reg.minute), .max_i(BCC_SEC_MAX), .min_i(BCC_BCD_ZERO),
    .next_o(step.minute), .wrap_o(m_wrap));
  bcc_bcd_step u_hour (.val_i(time_reg.hour), .max_i(BCC_HOUR_MAX), .min_i(BCC_BCD_ZERO),
    .next_o(step.hour), .wrap_o(h_wrap));
  bcc_bcd_step u_date (.val_i(time_reg.date), .max_i(dmax), .min_i(BCC_BCD_ONE),
    .next_o(step.date), .wrap_o(d_wrap));
  bcc_bcd_step u_month (.val_i(time_reg.month), .max_i(BCC_MONTH_MAX), .min_i(BCC_BCD_ONE),
    .next_o(step.month), .wrap_o(mo_wrap));
  bcc_bcd_step u_year (.val_i(time_reg.year), .max_i(BCC_YEAR_MAX), .min_i(BCC_BCD_ZERO),
    .next_o(step.year), .wrap_o());
  bcc_bcd_step u_wday (.val_i(time_reg.weekday), .max_i(BCC_WDAY_MAX), .min_i(BCC_BCD_ZERO),
    .next_o(step.weekday), .wrap_o());

  // Next time, control bits and prescaler
  always_comb
  begin
    time_next = time_reg;
    halt_next = halt_reg;
    load_next = load_reg;
    round_next = round_reg;
    presc_next = presc_reg;
    if (!cas_ok_reg)
    begin
      // cassette gone, clock stopped and time lost
      time_next = BCC_TIME_RST;
      halt_next = 1'b0;
      load_next = 1'b0;
      round_next = 1'b0;
      presc_next = '0;
    end
    else
    begin
      // restart the second from zero on load
      if (load_reg || !running_reg || tick)
        presc_next = '0;
      else
        presc_next = BCC_PRESC_W'(presc_reg + 1'b1);
      if (tick_run)
        time_next.second = step.second;
      if (round_reg)
        time_next.second = BCC_BCD_ZERO;
      if (min_step)
        time_next.minute = step.minute;
      if (hour_step)
        time_next.hour = step.hour;
      if (day_step)
      begin
        time_next.date = step.date;
        time_next.weekday = step.weekday;
      end
      if (month_step)
        time_next.month = step.month;
      if (year_step)
        time_next.year = step.year;
      if (load_reg)
      begin
        halt_next = 1'b0;
        load_next = 1'b0;
      end
      if (round_reg)
        round_next = 1'b0;
      // time words writable only while halted
      if (wr_en_i && halt_reg)
      begin
        case (addr_i)
          BCC_OFS_MIN_SEC:
          begin
            time_next.minute = wr_data_i[15:8];
            time_next.second = wr_data_i[7:0];
          end
          BCC_OFS_DATE_HOUR:
          begin
            time_next.date = wr_data_i[15:8];
            time_next.hour = wr_data_i[7:0];
          end
          BCC_OFS_YEAR_MONTH:
          begin
            time_next.year = wr_data_i[15:8];
            time_next.month = wr_data_i[7:0];
          end
          BCC_OFS_WDAY_CTL:
            time_next.weekday = wr_data_i[7:0];
          default:
            time_next = time_next;
        endcase
      end
      // control bits, a write setting a bit wins over self-clear
      if (wr_ctl)
      begin
        round_next = wr_data_i[BCC_BIT_ROUND];
        halt_next = wr_data_i[BCC_BIT_HALT];
        load_next = wr_data_i[BCC_BIT_LOAD];
      end
    end
  end

  // Quick word, read data and run status
  always_comb
  begin
    // hour and minute in one word
    quick_next = {time_next.hour, time_next.minute};
    running_next = cas_ok_reg && !halt_next;
    rd_data_next = rd_data_reg;
    if (rd_en_i)
    begin
      case (addr_i)
        BCC_OFS_QUICK: rd_data_next = quick_reg;
        BCC_OFS_MIN_SEC: rd_data_next = {time_reg.minute, time_reg.second};
        BCC_OFS_DATE_HOUR: rd_data_next = {time_reg.date, time_reg.hour};
        BCC_OFS_YEAR_MONTH: rd_data_next = {time_reg.year, time_reg.month};
        BCC_OFS_WDAY_CTL: rd_data_next = {load_reg, halt_reg, round_reg, 5'h00,
                                          time_reg.weekday};
        default: rd_data_next = 16'h0000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      time_reg <= BCC_TIME_RST;
      quick_reg <= 16'h0000;
      halt_reg <= 1'b0;
      load_reg <= 1'b0;
      round_reg <= 1'b0;
      presc_reg <= '0;
      rd_data_reg <= 16'h0000;
      running_reg <= 1'b0;
    end
    else
    begin
      time_reg <= time_next;
      quick_reg <= quick_next;
      halt_reg <= halt_next;
      load_reg <= load_next;
      round_reg <= round_next;
      presc_reg <= presc_next;
      rd_data_reg <= rd_data_next;
      running_reg <= running_next;
    end
  end

  assign rd_data_o = rd_data_reg;
  assign running_o = running_reg;

  // Halted time holds still
  property p_halt_freeze;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (halt_reg && !load_reg && !round_reg && !wr_en_i && cas_ok_reg)
      |=> (time_reg == $past(time_reg));
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("time moved while halted");

  // Load clears halt and load
  property p_load_clear;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (load_reg && cas_ok_reg && !wr_ctl) |=> (!load_reg && !halt_reg);
  endproperty
  a_load_clear: assert property (p_load_clear) else $error("load did not self-clear");

  // Load restarts the second count and runs at once
  property p_load_restart;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (load_reg && cas_ok_reg && !wr_ctl) |=> (presc_reg == '0 && running_reg);
  endproperty
  a_load_restart: assert property (p_load_restart) else $error("load did not restart");

  // Rounding low half keeps minute
  property p_round_low;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (round_reg && cas_ok_reg && !wr_en_i && time_reg.second < BCC_SEC_HALF)
      |=> (time_reg.second == BCC_BCD_ZERO && time_reg.minute == $past(time_reg.minute));
  endproperty
  a_round_low: assert property (p_round_low) else $error("low rounding wrong");

  // Rounding high half advances minute
  property p_round_high;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (round_reg && cas_ok_reg && !wr_en_i && time_reg.second >= BCC_SEC_HALF)
      |=> (time_reg.second == BCC_BCD_ZERO && time_reg.minute != $past(time_reg.minute));
  endproperty
  a_round_high: assert property (p_round_high) else $error("high rounding wrong");

  // Rounding request clears itself
  property p_round_clear;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (round_reg && !wr_ctl) |=> !round_reg;
  endproperty
  a_round_clear: assert property (p_round_clear) else $error("rounding bit stuck");

  // Cassette loss resets time and stops clock
  property p_cassette_loss;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !cas_ok_reg |=> (time_reg == BCC_TIME_RST && !running_reg);
  endproperty
  a_cassette_loss: assert property (p_cassette_loss) else $error("time kept without cassette");

  // Quick word read returns the current hour and minute
  property p_quick_mirror;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (rd_en_i && addr_i == BCC_OFS_QUICK)
      |=> (rd_data_reg == {$past(time_reg.hour), $past(time_reg.minute)});
  endproperty
  a_quick_mirror: assert property (p_quick_mirror) else $error("quick word stale");

endmodule
`default_nettype wire

// >>> hw/bcc_pkg.sv
// Package with register map, field layout and timing constants of the calendar clock
package bcc_pkg;

  // Word offsets of the register file
  localparam logic [7:0] BCC_OFS_QUICK = 8'h11;
  localparam logic [7:0] BCC_OFS_MIN_SEC = 8'h12;
  localparam logic [7:0] BCC_OFS_DATE_HOUR = 8'h13;
  localparam logic [7:0] BCC_OFS_YEAR_MONTH = 8'h14;
  localparam logic [7:0] BCC_OFS_WDAY_CTL = 8'h15;

  // Control word bit positions
  localparam int BCC_BIT_ROUND = 13;
  localparam int BCC_BIT_HALT = 14;
  localparam int BCC_BIT_LOAD = 15;

  // BCD field limits
  localparam logic [7:0] BCC_BCD_ZERO = 8'h00;
  localparam logic [7:0] BCC_BCD_ONE = 8'h01;
  localparam logic [7:0] BCC_BCD_NINE = 8'h09;
  localparam logic [7:0] BCC_SEC_MAX = 8'h59;
  localparam logic [7:0] BCC_SEC_HALF = 8'h30;
  localparam logic [7:0] BCC_HOUR_MAX = 8'h23;
  localparam logic [7:0] BCC_MONTH_MAX = 8'h12;
  localparam logic [7:0] BCC_YEAR_MAX = 8'h99;
  localparam logic [7:0] BCC_WDAY_MAX = 8'h06;
  localparam logic [7:0] BCC_DAYS_31 = 8'h31;
  localparam logic [7:0] BCC_DAYS_30 = 8'h30;
  localparam logic [7:0] BCC_DAYS_29 = 8'h29;
  localparam logic [7:0] BCC_DAYS_28 = 8'h28;
  localparam logic [7:0] BCC_MON_FEB = 8'h02;
  localparam logic [7:0] BCC_MON_APR = 8'h04;
  localparam logic [7:0] BCC_MON_JUN = 8'h06;
  localparam logic [7:0] BCC_MON_SEP = 8'h09;
  localparam logic [7:0] BCC_MON_NOV = 8'h11;

  // Timing: one second at the system clock rate
  localparam int BCC_CLK_PERIOD_NS = 25;
  localparam int BCC_SECOND_NS = 1000000000;
  localparam int BCC_SECOND_CYCLES = BCC_SECOND_NS / BCC_CLK_PERIOD_NS;
  localparam int BCC_PRESC_W = 26;

  // Calendar time, one BCD byte per field
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
    logic [7:0] weekday;
  } bcc_time_t;

  // Time after reset or cassette loss: 00-01-01 00:00:00, Sunday
  localparam bcc_time_t BCC_TIME_RST = '{
    year: 8'h00, month: 8'h01, date: 8'h01, hour: 8'h00,
    minute: 8'h00, second: 8'h00, weekday: 8'h00};

  // Last date of a month, leap year every fourth BCD year
  function automatic logic [7:0] bcc_month_days(input logic [7:0] month, input logic [7:0] year);
    logic leap;
    leap = (year[4] == 1'b0) ? (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8)
                             : (year[3:0] == 4'h2 || year[3:0] == 4'h6);
    if (month == BCC_MON_FEB)
      return leap ? BCC_DAYS_29 : BCC_DAYS_28;
    else if (month == BCC_MON_APR || month == BCC_MON_JUN || month == BCC_MON_SEP ||
             month == BCC_MON_NOV)
      return BCC_DAYS_30;
    else
      return BCC_DAYS_31;
  endfunction

endpackage

// >>> sim/bcc_clock_bench.sv
// Self-checking bench for the calendar clock block
`timescale 1ns/1ps
`default_nettype none
module bcc_clock_bench
  import bcc_pkg::*;
;
  localparam int SEC_CYC = 8;
  // Design connections
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cassette_present_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic wr_en_i = 1'b0;
  logic [15:0] wr_data_i = 16'h0000;
  logic rd_en_i = 1'b0;
  logic [15:0] rd_data_o;
  logic running_o;
  // Bench bookkeeping
  logic rd_q = 1'b0;
  logic [15:0] exp_q[$];
  int fails = 0;
  int samples_checked = 0;
  integer seed = 48217;
  bcc_time_t st [4];
  bcc_time_t et [4];
  int ns [4];
  bcc_time_t t;
  logic [7:0] sec;
  logic [7:0] mnt;

  bcc_clock #(.SECOND_CYCLES(SEC_CYC)) dut_u (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .cassette_present_i(cassette_present_i),
    .addr_i(addr_i),
    .wr_en_i(wr_en_i),
    .wr_data_i(wr_data_i),
    .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o),
    .running_o(running_o)
  );

  // Free-running system clock
  always #12.5 sys_clk_i = ~sys_clk_i;

  // Compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic test_done();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One write strobe, taken at the second edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_en_i <= 1'b0;
  endtask

  // One read strobe; expected word goes into the queue
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk_i);
    rd_en_i <= 1'b0;
  endtask

  // Halt, then write all time words and the weekday
  task automatic set_time(input bcc_time_t v);
    wr(BCC_OFS_WDAY_CTL, 16'h4000);
    wr(BCC_OFS_MIN_SEC, {v.minute, v.second});
    wr(BCC_OFS_DATE_HOUR, {v.date, v.hour});
    wr(BCC_OFS_YEAR_MONTH, {v.year, v.month});
    // Unused control bits written high must read back as zero
    wr(BCC_OFS_WDAY_CTL, {8'h5F, v.weekday});
  endtask

  // Read every word of the map
  task automatic rd_all(input bcc_time_t v, input logic [7:0] ctl);
    rd(BCC_OFS_QUICK, {v.hour, v.minute});
    rd(BCC_OFS_MIN_SEC, {v.minute, v.second});
    rd(BCC_OFS_DATE_HOUR, {v.date, v.hour});
    rd(BCC_OFS_YEAR_MONTH, {v.year, v.month});
    rd(BCC_OFS_WDAY_CTL, {ctl, v.weekday});
  endtask

  // Bench-side BCD increment below 59
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // Read data lands at the same edge that takes the strobe
  always @(posedge sys_clk_i)
    rd_q <= rd_en_i;

  // Monitor: oldest note against each answer
  always @(negedge sys_clk_i)
    if (rd_q)
      check(rd_data_o, exp_q.pop_front());

  // Watchdog against a hang
  initial
  begin
    repeat (6000) @(posedge sys_clk_i);
    fails++;
    test_done();
  end

  // Main sequence
  initial
  begin
    st[0] = 56'h99123123595806;
    et[0] = 56'h00010100000000;
    ns[0] = 2;
    st[1] = 56'h04022823595903;
    et[1] = 56'h04022900000004;
    ns[1] = 1;
    st[2] = 56'h05022823595903;
    et[2] = 56'h05030100000004;
    ns[2] = 1;
    st[3] = 56'h21043023595902;
    et[3] = 56'h21050100000003;
    ns[3] = 1;
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check({15'h0000, running_o}, 16'h0001);
    t = 56'h12071510203005;
    set_time(t);
    rd_all(t, 8'h40);
    @(negedge sys_clk_i);
    check({15'h0000, running_o}, 16'h0000);
    repeat (3 * SEC_CYC) @(posedge sys_clk_i);
    rd(BCC_OFS_MIN_SEC, {t.minute, t.second});
    wr(BCC_OFS_QUICK, 16'hFFFF);
    rd(BCC_OFS_QUICK, {t.hour, t.minute});
    rd(8'h3C, 16'h0000);
    $display("test set and halt done");
    for (int i = 0; i < 8; i++)
    begin
      mnt = {4'($unsigned($random(seed)) % 5), 4'($unsigned($random(seed)) % 10)};
      sec = {4'($unsigned($random(seed)) % 6), 4'($unsigned($random(seed)) % 10)};
      sec = (i == 0) ? 8'h29 : (i == 1) ? 8'h30 : sec;
      wr(BCC_OFS_MIN_SEC, {mnt, sec});
      wr(BCC_OFS_WDAY_CTL, {8'h60, t.weekday});
      @(posedge sys_clk_i);
      rd(BCC_OFS_MIN_SEC, {(sec >= 8'h30) ? bcd_inc(mnt) : mnt, 8'h00});
      rd(BCC_OFS_WDAY_CTL, {8'h40, t.weekday});
    end
    $display("test rounding done");
    for (int k = 0; k < 4; k++)
    begin
      set_time(st[k]);
      wr(BCC_OFS_WDAY_CTL, {8'hC0, st[k].weekday});
      @(posedge sys_clk_i);
      rd(BCC_OFS_WDAY_CTL, {8'h00, st[k].weekday});
      @(negedge sys_clk_i);
      check({15'h0000, running_o}, 16'h0001);
      repeat (SEC_CYC * ns[k] + 1) @(posedge sys_clk_i);
      wr(BCC_OFS_WDAY_CTL, 16'h4000);
      rd_all(et[k], 8'h40);
    end
    $display("test load and count done");
    @(posedge sys_clk_i);
    cassette_present_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check({15'h0000, running_o}, 16'h0000);
    wr(BCC_OFS_WDAY_CTL, 16'h4000);
    rd_all(BCC_TIME_RST, 8'h00);
    @(posedge sys_clk_i);
    cassette_present_i <= 1'b1;
    for (int j = 0; j < 10 && running_o !== 1'b1; j++)
      @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check({15'h0000, running_o}, 16'h0001);
    $display("test cassette removal done");
    repeat (3) @(posedge sys_clk_i);
    check(16'(exp_q.size()), 16'h0000);
    test_done();
  end
endmodule
`default_nettype wire
